// >>> hw/seecmd_defines.vh
`ifndef SEECMD_DEFINES_VH
`define SEECMD_DEFINES_VH

// opcodes
`define SEECMD_OP_SET_LATCH 8'h06
`define SEECMD_OP_CLR_LATCH 8'h04
`define SEECMD_OP_STAT_RD 8'h05
`define SEECMD_OP_STAT_WR 8'h01
`define SEECMD_OP_MEM_RD 8'h03
`define SEECMD_OP_MEM_WR 8'h02

// status byte field positions
`define SEECMD_ST_LOCK 7
`define SEECMD_ST_AREA_HI 3
`define SEECMD_ST_AREA_LO 2
`define SEECMD_ST_LATCH 1
`define SEECMD_ST_BUSY 0

// frame lengths in link clocks
`define SEECMD_N_OPCODE 8
`define SEECMD_N_STAT_WR 16
`define SEECMD_N_ADDR_END 24

// initial contents
`define SEECMD_MEM_INIT 8'hFF
`define SEECMD_AREA_INIT 2'h0
`define SEECMD_LOCK_INIT 1'b0

// internal write time in microseconds, clock rate in MHz
`define SEECMD_WRITE_TIME_US 5000
`define SEECMD_CLK_MHZ 50
`define SEECMD_WRITE_CYCLES (`SEECMD_WRITE_TIME_US * `SEECMD_CLK_MHZ)

`endif

// >>> hw/seecmd_fifo.v
`timescale 1ns/1ps
module seecmd_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    // clock and reset
    input wire core_clk,
    input wire reset_n,
    input wire clkEn,
    input wire flush,
    // fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // drain side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_r;
    reg [AW-1:0] rdPtr_r;
    reg [AW:0] count_r;
    wire doWr;
    wire doRd;

    // handshake terms
    assign inReady = (count_r != DEPTH[AW:0]);
    assign outValid = (count_r != {(AW+1){1'b0}});
    assign outData = mem[rdPtr_r];
    assign doWr = inValid && inReady && clkEn;
    assign doRd = outValid && outReady && clkEn;

    // storage
    always @(posedge core_clk)
    begin
        if (doWr)
            mem[wrPtr_r] <= inData;
    end

    // pointers and fill count
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end
        else if (clkEn)
        begin
            if (flush)
            begin
                wrPtr_r <= {AW{1'b0}};
                rdPtr_r <= {AW{1'b0}};
                count_r <= {(AW+1){1'b0}};
            end
            else
            begin
                if (doWr)
                    wrPtr_r <= wrPtr_r + 1'b1;
                if (doRd)
                    rdPtr_r <= rdPtr_r + 1'b1;
                if (doWr && !doRd)
                    count_r <= count_r + 1'b1;
                else if (doRd && !doWr)
                    count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// >>> hw/seecmd_core.v
`timescale 1ns/1ps
`include "seecmd_defines.vh"
module seecmd_core #(
    parameter ADDR_BITS = 10,
    parameter WRITE_CYCLES = `SEECMD_WRITE_CYCLES,
    parameter FIFO_DEPTH = 32
) (
    // clock, reset, enable
    input wire core_clk,
    input wire reset_n,
    input wire clkEn,
    // serial link pins
    input wire linkSelectN,
    input wire linkClk,
    input wire linkDataIn,
    output reg linkDataOut_r,
    output reg linkDataOutEn_r,
    // protection and supply
    input wire writeProtectN,
    input wire supplyLow,
    // internal write request to the cell writer, one byte per word
    output reg memWrActive_r,
    output reg [ADDR_BITS-1:0] memWrAddr_r,
    output reg [7:0] memWrData_r,
    output reg memWrValid_r,
    input wire memWrReady,
    // status byte
    output reg [7:0] writeProtectStatus_r,
    output reg busyWritingFlag_r
);
    localparam CNT_W = 9; // room for opcode, address and a 32-byte page
    localparam ST_IDLE = 3'h0;
    localparam ST_OPC = 3'h1;
    localparam ST_IGNORE = 3'h2;
    localparam ST_STRD = 3'h3;
    localparam ST_STWR = 3'h4;
    localparam ST_MRD = 3'h5;
    localparam ST_MWR = 3'h6;

    // pin synchronisers: two flops before any logic
    reg [1:0] selSync_r;
    reg [1:0] sckSync_r;
    reg [1:0] sdiSync_r;
    reg [1:0] wpSync_r;
    reg [1:0] lowSync_r;
    reg sckPrev_r;
    reg selPrev_r;
    wire selected = ~selSync_r[1];
    wire sckRise = sckSync_r[1] & ~sckPrev_r;
    wire sckFall = ~sckSync_r[1] & sckPrev_r;
    wire selRise = ~selPrev_r & selSync_r[1];
    wire supplyDrop = lowSync_r[1];

    // frame state
    reg [2:0] state_r;
    reg [CNT_W-1:0] bitCnt_r;
    reg [7:0] shiftIn_r;
    reg [7:0] opcode_r;
    reg [7:0] shiftOut_r;
    reg [2:0] outBit_r;
    reg [15:0] addrIn_r;
    reg [ADDR_BITS-1:0] rdAddr_r;
    reg [7:0] stDataIn_r;

    // status bits
    reg writeLatchBit_r;
    reg statusLockBit_r;
    reg [1:0] protectArea_r;
    reg stPending_r;
    reg [7:0] stPendingData_r;
    reg [31:0] writeTimer_r;
    reg memWrBusy_r;

    // array model
    reg [7:0] mem [0:(1<<ADDR_BITS)-1];

    // page fifo between frame and cell writer
    wire fifoInReady;
    wire fifoOutValid;
    wire [7:0] fifoOutData;
    reg fifoPush;
    reg [7:0] fifoPushData;
    reg fifoFlush;
    reg [ADDR_BITS-1:0] mwAddr_r;

    wire hardwareLockMode = statusLockBit_r & ~wpSync_r[1];
    wire [7:0] rxByte = {shiftIn_r[6:0], sdiSync_r[1]};
    // busy bit from the same source as the busy flag, so both agree
    wire [7:0] liveStatus = {statusLockBit_r, 3'h0, protectArea_r,
                             writeLatchBit_r, stPending_r | memWrBusy_r};

    // area guard: 01 top quarter, 10 top half, 11 all
    function guarded;
        input [1:0] area;
        input [ADDR_BITS-1:0] a;
        begin
            case (area)
                2'h1: guarded = (a[ADDR_BITS-1:ADDR_BITS-2] == 2'h3);
                2'h2: guarded = a[ADDR_BITS-1];
                2'h3: guarded = 1'b1;
                default: guarded = 1'b0;
            endcase
        end
    endfunction

    // memory write may start: latch set, whole bytes, start address unguarded
    wire memWrStart = writeLatchBit_r && fifoOutValid && bitCnt_r[2:0] == 3'h0
                      && !guarded(protectArea_r, mwAddr_r);

    seecmd_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(5)
    ) u_fifo (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .flush(fifoFlush),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .inData(fifoPushData),
        .outValid(fifoOutValid),
        .outReady(memWrActive_r & ~memWrValid_r),
        .outData(fifoOutData)
    );

    // initial array contents
    integer i;
    initial
    begin
        for (i = 0; i < (1<<ADDR_BITS); i = i + 1)
            mem[i] = `SEECMD_MEM_INIT;
    end

    // cell writer stores accepted words
    always @(posedge core_clk)
    begin
        if (clkEn && memWrValid_r && memWrReady)
            mem[memWrAddr_r] <= memWrData_r;
    end

    // synchronisers and edge history
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            selSync_r <= 2'h3;
            sckSync_r <= 2'h0;
            sdiSync_r <= 2'h0;
            wpSync_r <= 2'h3;
            lowSync_r <= 2'h0;
            sckPrev_r <= 1'b0;
            selPrev_r <= 1'b1;
        end
        else if (clkEn)
        begin
            selSync_r <= {selSync_r[0], linkSelectN};
            sckSync_r <= {sckSync_r[0], linkClk};
            sdiSync_r <= {sdiSync_r[0], linkDataIn};
            wpSync_r <= {wpSync_r[0], writeProtectN};
            lowSync_r <= {lowSync_r[0], supplyLow};
            sckPrev_r <= sckSync_r[1];
            selPrev_r <= selSync_r[1];
        end
    end

    // page fifo push from frame decode
    always @*
    begin
        fifoPush = 1'b0;
        fifoPushData = rxByte[7:0];
        fifoFlush = supplyDrop;
        if (state_r == ST_MWR && selected && sckRise && bitCnt_r[2:0] == 3'h7
            && bitCnt_r >= `SEECMD_N_ADDR_END + 7 && fifoInReady)
            fifoPush = 1'b1;
        // a write that does not start leaves no stale bytes behind
        if (state_r == ST_MWR && selRise && !memWrStart)
            fifoFlush = 1'b1;
    end

    // frame decoder, status machine and internal write timer
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ST_IDLE;
            bitCnt_r <= {CNT_W{1'b0}};
            shiftIn_r <= 8'h00;
            opcode_r <= 8'h00;
            shiftOut_r <= 8'h00;
            outBit_r <= 3'h0;
            addrIn_r <= 16'h0000;
            rdAddr_r <= {ADDR_BITS{1'b0}};
            stDataIn_r <= 8'h00;
            writeLatchBit_r <= 1'b0;
            statusLockBit_r <= `SEECMD_LOCK_INIT;
            protectArea_r <= `SEECMD_AREA_INIT;
            stPending_r <= 1'b0;
            stPendingData_r <= 8'h00;
            writeTimer_r <= 32'h0;
            memWrBusy_r <= 1'b0;
            busyWritingFlag_r <= 1'b0;
            linkDataOut_r <= 1'b0;
            linkDataOutEn_r <= 1'b0;
            memWrActive_r <= 1'b0;
            memWrAddr_r <= {ADDR_BITS{1'b0}};
            memWrData_r <= 8'h00;
            memWrValid_r <= 1'b0;
            mwAddr_r <= {ADDR_BITS{1'b0}};
            writeProtectStatus_r <= 8'h00;
        end
        else if (clkEn)
        begin
            writeProtectStatus_r <= liveStatus;
            busyWritingFlag_r <= stPending_r | memWrBusy_r;
            // drain the page fifo into the cell writer during the write
            if (memWrValid_r && memWrReady)
            begin
                memWrValid_r <= 1'b0;
                memWrAddr_r <= memWrAddr_r + 1'b1;
            end
            else if (memWrActive_r && !memWrValid_r && fifoOutValid)
            begin
                memWrValid_r <= 1'b1;
                memWrData_r <= fifoOutData;
            end
            // internal write timer
            if (stPending_r || memWrBusy_r)
            begin
                if (writeTimer_r == 32'h0)
                begin
                    if (stPending_r)
                    begin
                        statusLockBit_r <= stPendingData_r[`SEECMD_ST_LOCK];
                        protectArea_r <= stPendingData_r[3:2];
                    end
                    if (!fifoOutValid && !memWrValid_r)
                    begin
                        stPending_r <= 1'b0;
                        memWrBusy_r <= 1'b0;
                        memWrActive_r <= 1'b0;
                        writeLatchBit_r <= 1'b0;
                    end
                end
                else
                    writeTimer_r <= writeTimer_r - 1'b1;
            end
            // link side
            if (!selected)
            begin
                state_r <= ST_IDLE;
                linkDataOutEn_r <= 1'b0;
                bitCnt_r <= {CNT_W{1'b0}};
                if (selRise)
                begin
                    if (state_r == ST_OPC && bitCnt_r == `SEECMD_N_OPCODE)
                    begin
                        if (opcode_r == `SEECMD_OP_SET_LATCH)
                            writeLatchBit_r <= 1'b1;
                        if (opcode_r == `SEECMD_OP_CLR_LATCH)
                            writeLatchBit_r <= 1'b0;
                    end
                    if (state_r == ST_STWR && bitCnt_r == `SEECMD_N_STAT_WR
                        && writeLatchBit_r && !hardwareLockMode)
                    begin
                        stPending_r <= 1'b1;
                        stPendingData_r <= stDataIn_r;
                        writeTimer_r <= WRITE_CYCLES - 1;
                    end
                    if (state_r == ST_MWR && memWrStart)
                    begin
                        memWrBusy_r <= 1'b1;
                        memWrActive_r <= 1'b1;
                        memWrAddr_r <= mwAddr_r;
                        writeTimer_r <= WRITE_CYCLES - 1;
                    end
                end
            end
            else if (state_r == ST_IDLE && selPrev_r)
            begin
                state_r <= ST_OPC;
                bitCnt_r <= {CNT_W{1'b0}};
            end
            else if (sckRise && state_r != ST_IGNORE)
            begin
                shiftIn_r <= rxByte[7:0];
                if (bitCnt_r != {CNT_W{1'b1}})
                    bitCnt_r <= bitCnt_r + 1'b1;
                case (state_r)
                    ST_OPC:
                    begin
                        if (bitCnt_r == `SEECMD_N_OPCODE - 1)
                        begin
                            opcode_r <= rxByte[7:0];
                            case (rxByte[7:0])
                                `SEECMD_OP_SET_LATCH,
                                `SEECMD_OP_CLR_LATCH: state_r <= ST_OPC;
                                `SEECMD_OP_STAT_RD:
                                begin
                                    state_r <= ST_STRD;
                                    shiftOut_r <= liveStatus;
                                    outBit_r <= 3'h7;
                                end
                                `SEECMD_OP_STAT_WR: state_r <= ST_STWR;
                                `SEECMD_OP_MEM_RD:
                                    state_r <= (busyWritingFlag_r) ? ST_IGNORE : ST_MRD;
                                `SEECMD_OP_MEM_WR:
                                    state_r <= (busyWritingFlag_r) ? ST_IGNORE : ST_MWR;
                                default: state_r <= ST_IGNORE;
                            endcase
                        end
                    end
                    ST_STWR:
                    begin
                        if (bitCnt_r == `SEECMD_N_STAT_WR - 1)
                            stDataIn_r <= rxByte[7:0];
                    end
                    ST_MRD:
                    begin
                        if (bitCnt_r < `SEECMD_N_ADDR_END)
                            addrIn_r <= {addrIn_r[14:0], sdiSync_r[1]};
                        if (bitCnt_r == `SEECMD_N_ADDR_END - 1)
                        begin
                            rdAddr_r <= {addrIn_r[ADDR_BITS-2:0], sdiSync_r[1]};
                            outBit_r <= 3'h7;
                        end
                    end
                    ST_MWR:
                    begin
                        if (bitCnt_r < `SEECMD_N_ADDR_END)
                            addrIn_r <= {addrIn_r[14:0], sdiSync_r[1]};
                        if (bitCnt_r == `SEECMD_N_ADDR_END - 1)
                            mwAddr_r <= {addrIn_r[ADDR_BITS-2:0], sdiSync_r[1]};
                    end
                    default: state_r <= state_r;
                endcase
            end
            else if (sckFall && (state_r == ST_STRD || (state_r == ST_MRD
                     && bitCnt_r >= `SEECMD_N_ADDR_END)))
            begin
                // serial output changes after falling edge
                linkDataOutEn_r <= 1'b1;
                if (state_r == ST_STRD)
                begin
                    linkDataOut_r <= shiftOut_r[outBit_r];
                    if (outBit_r == 3'h0)
                        shiftOut_r <= liveStatus;
                end
                else
                begin
                    linkDataOut_r <= mem[rdAddr_r][outBit_r];
                    if (outBit_r == 3'h0)
                        rdAddr_r <= rdAddr_r + 1'b1;
                end
                outBit_r <= outBit_r - 1'b1;
            end
            // supply drop aborts any write and clears the latch
            if (supplyDrop)
            begin
                writeLatchBit_r <= 1'b0;
                stPending_r <= 1'b0;
                memWrBusy_r <= 1'b0;
                memWrActive_r <= 1'b0;
                memWrValid_r <= 1'b0;
            end
        end
    end
endmodule

// >>> dv/seecmd_core_props.sv
`timescale 1ns/1ps
module seecmd_core_chk #(
    parameter WRITE_CYCLES = 50
) (
    // clock and reset
    input wire core_clk,
    input wire reset_n,
    // pins
    input wire linkSelectN,
    input wire linkClk,
    input wire supplyLow,
    input wire linkDataOut_r,
    input wire linkDataOutEn_r,
    // status
    input wire [7:0] writeProtectStatus_r,
    input wire busyWritingFlag_r
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    integer busyCnt;
    // length of the current busy stretch
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            busyCnt <= 0;
        else if (busyWritingFlag_r)
            busyCnt <= busyCnt + 1;
        else
            busyCnt <= 0;
    end
    sequence s_deselHeld;
        linkSelectN [*6];
    endsequence
    sequence s_supplyHeld;
        supplyLow [*5];
    endsequence
    property p_busyBit;
        busyWritingFlag_r == writeProtectStatus_r[0];
    endproperty
    a_busyBit: assert property (p_busyBit) else $error("busy bit differs from flag");
    property p_zeroBits;
        writeProtectStatus_r[6:4] == 3'h0;
    endproperty
    a_zeroBits: assert property (p_zeroBits) else $error("status bits 6-4 not zero");
    property p_release;
        s_deselHeld |-> !linkDataOutEn_r;
    endproperty
    a_release: assert property (p_release) else $error("output driven while deselected");
    property p_latchSet;
        $rose(writeProtectStatus_r[1]) |-> $past(linkSelectN, 2);
    endproperty
    a_latchSet: assert property (p_latchSet) else $error("latch set inside a frame");
    property p_supply;
        s_supplyHeld |-> !writeProtectStatus_r[1];
    endproperty
    a_supply: assert property (p_supply) else $error("latch kept on supply drop");
    property p_busyLen;
        $fell(busyWritingFlag_r) && !supplyLow |->
            busyCnt >= WRITE_CYCLES - 1 && busyCnt <= WRITE_CYCLES + 64;
    endproperty
    a_busyLen: assert property (p_busyLen) else $error("busy length wrong");
    property p_latchAtEnd;
        $fell(busyWritingFlag_r) |-> ##[0:1] !writeProtectStatus_r[1];
    endproperty
    a_latchAtEnd: assert property (p_latchAtEnd) else $error("latch kept after write");
    property p_areaHold;
        $changed({writeProtectStatus_r[7], writeProtectStatus_r[3:2]}) |->
            !busyWritingFlag_r && ($past(busyWritingFlag_r) || $past(busyWritingFlag_r, 2));
    endproperty
    a_areaHold: assert property (p_areaHold) else $error("lock or area changed early");
    property p_outAfterFall;
        linkDataOutEn_r && $past(linkDataOutEn_r) && $changed(linkDataOut_r) |->
            !$past(linkClk, 2) || !$past(linkClk, 3) || !$past(linkClk, 4);
    endproperty
    a_outAfterFall: assert property (p_outAfterFall) else $error("output moved off a fall");
endmodule

bind seecmd_core seecmd_core_chk #(.WRITE_CYCLES(WRITE_CYCLES)) seecmd_core_chk_i (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .linkSelectN(linkSelectN),
    .linkClk(linkClk),
    .supplyLow(supplyLow),
    .linkDataOut_r(linkDataOut_r),
    .linkDataOutEn_r(linkDataOutEn_r),
    .writeProtectStatus_r(writeProtectStatus_r),
    .busyWritingFlag_r(busyWritingFlag_r)
);

// >>> dv/seecmd_host.sv
`timescale 1ns/1ps
module seecmd_host (
    // clock
    input wire core_clk,
    // link pins
    output reg linkSelectN,
    output reg linkClk,
    output reg linkDataIn,
    input wire linkDataOut_r,
    input wire linkDataOutEn_r
);
    // idle: deselected, link clock still low
    initial
    begin
        linkSelectN = 1'b1;
        linkClk = 1'b0;
        linkDataIn = 1'b0;
    end
    // one frame, msb first, 160 ns link clock, output sampled before each rise
    task frame(input [47:0] tx, input integer n, output [47:0] rx, output en);
        integer i;
        begin
            rx = 48'h0;
            en = 1'b0;
            @(posedge core_clk) linkSelectN <= 1'b0;
            repeat (4) @(posedge core_clk);
            for (i = n - 1; i >= 0; i = i - 1)
            begin
                linkClk <= 1'b0;
                linkDataIn <= tx[i];
                repeat (3) @(posedge core_clk);
                @(negedge core_clk);
                // a released output line reads as the inverse of the last bit
                rx = {rx[46:0], linkDataOutEn_r ? linkDataOut_r : ~linkDataOut_r};
                en = en | linkDataOutEn_r;
                @(posedge core_clk) linkClk <= 1'b1;
                repeat (4) @(posedge core_clk);
            end
            linkClk <= 1'b0;
            repeat (2) @(posedge core_clk);
            linkSelectN <= 1'b1;
            linkDataIn <= ~linkDataIn;
            repeat (8) @(posedge core_clk);
        end
    endtask
endmodule

// >>> dv/seecmd_core_test.sv
`timescale 1ns/1ps
module seecmd_core_test;
    localparam WCYC = 2000;
    reg core_clk;
    reg reset_n;
    reg writeProtectN;
    reg supplyLow;
    reg memWrReady;
    reg clkEn;
    wire linkSelectN, linkClk, linkDataIn, linkDataOut_r, linkDataOutEn_r;
    wire [7:0] writeProtectStatus_r;
    wire busyWritingFlag_r;
    wire memWrActive_r, memWrValid_r;
    wire [9:0] memWrAddr_r;
    wire [7:0] memWrData_r;
    reg [9:0] lastWrAddr = 10'h3FF;
    reg [7:0] lastWrData = 8'h00;
    integer error_cnt;
    integer n_checks;
    reg [47:0] rx;
    reg en;
    // system clock, 50 MHz
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    seecmd_core #(.ADDR_BITS(10), .WRITE_CYCLES(WCYC), .FIFO_DEPTH(32)) seecmd_core_i (
        .core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
        .linkSelectN(linkSelectN), .linkClk(linkClk), .linkDataIn(linkDataIn),
        .linkDataOut_r(linkDataOut_r), .linkDataOutEn_r(linkDataOutEn_r),
        .writeProtectN(writeProtectN), .supplyLow(supplyLow),
        .memWrActive_r(memWrActive_r), .memWrAddr_r(memWrAddr_r),
        .memWrData_r(memWrData_r), .memWrValid_r(memWrValid_r),
        .memWrReady(memWrReady), .writeProtectStatus_r(writeProtectStatus_r),
        .busyWritingFlag_r(busyWritingFlag_r)
    );
    // last word handed to the cell writer
    always @(posedge core_clk)
    begin
        if (memWrValid_r && memWrReady)
        begin
            lastWrAddr <= memWrAddr_r;
            lastWrData <= memWrData_r;
        end
    end
    seecmd_host seecmd_host_i (
        .core_clk(core_clk), .linkSelectN(linkSelectN), .linkClk(linkClk),
        .linkDataIn(linkDataIn), .linkDataOut_r(linkDataOut_r),
        .linkDataOutEn_r(linkDataOutEn_r)
    );
    // compare and count
    task chk(input string what, input [15:0] seen, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("FAIL %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // status byte port at a settled point
    task chkSt(input string what, input [7:0] exp);
        begin
            @(negedge core_clk);
            chk(what, {8'h00, writeProtectStatus_r}, {8'h00, exp});
        end
    endtask
    // verdict
    task end_sim;
        begin
            $display("counts: %0d checks, %0d mismatches", n_checks, error_cnt);
            if (error_cnt == 0 && n_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // one link frame through the host
    task xf(input [47:0] tx, input integer n);
        seecmd_host_i.frame(tx, n, rx, en);
    endtask
    // bounded wait on the busy flag
    task waitBusy(input v);
        integer i;
        begin
            i = 0;
            while (busyWritingFlag_r !== v && i < 6000)
            begin
                @(negedge core_clk);
                i = i + 1;
            end
            if (i == 6000)
            begin
                error_cnt = error_cnt + 1;
                $display("FAIL busy wait expected %h seen %h", v, busyWritingFlag_r);
                end_sim;
            end
        end
    endtask
    // main sequence
    initial
    begin
        error_cnt = 0;
        n_checks = 0;
        reset_n = 1'b0;
        writeProtectN = 1'b1;
        supplyLow = 1'b0;
        memWrReady = 1'b1;
        clkEn = 1'b1;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        xf({8'h05, 16'h0}, 24);
        chk("status after reset", rx[15:0], 16'h0000);
        $display("test reset done");
        xf(48'h03, 7);
        chkSt("set latch 7 clocks", 8'h00);
        xf(48'h06, 8);
        chkSt("set latch 8 clocks", 8'h02);
        xf({8'h05, 16'h0}, 24);
        chk("status read repeat", rx[15:0], 16'h0202);
        xf(48'h008, 9);
        chkSt("clear latch 9 clocks", 8'h02);
        xf(48'h04, 8);
        chkSt("clear latch 8 clocks", 8'h00);
        $display("test latch done");
        xf(48'h01FF, 16);
        chkSt("status write no latch", 8'h00);
        xf(48'h06, 8);
        xf(48'h00FF, 15);
        chkSt("status write 15 clocks", 8'h02);
        xf(48'h01FF, 16);
        chkSt("status write busy", 8'h03);
        xf({8'h05, 16'h0}, 24);
        chk("status read in write", rx[15:0], 16'h0303);
        xf({8'h03, 16'h0, 8'h0}, 32);
        chk("read refused in write", {15'h0, en}, 16'h0000);
        waitBusy(1'b0);
        chkSt("status write done", 8'h8C);
        xf({8'h05, 16'h0}, 24);
        chk("status read new", rx[15:0], 16'h8C8C);
        xf(48'h06, 8);
        xf({8'h02, 16'h0000, 8'h00}, 32);
        chkSt("guarded write refused", 8'h8E);
        $display("test status write done");
        @(posedge core_clk);
        writeProtectN <= 1'b0;
        xf(48'h06, 8);
        xf(48'h0100, 16);
        chkSt("hardware lock", 8'h8E);
        @(posedge core_clk);
        writeProtectN <= 1'b1;
        xf(48'h0100, 16);
        waitBusy(1'b0);
        chkSt("lock released", 8'h00);
        $display("test lock done");
        xf({8'h07, 16'h0}, 24);
        chk("unknown opcode", {15'h0, en}, 16'h0000);
        xf(48'h06, 8);
        xf({8'h02, 16'h0000, 8'h5A}, 32);
        chkSt("memory write busy", 8'h03);
        chk("drain active", {15'h0, memWrActive_r}, 16'h0001);
        waitBusy(1'b0);
        chkSt("memory write done", 8'h00);
        chk("cell write address", {6'h00, lastWrAddr}, 16'h0000);
        chk("cell write data", {8'h00, lastWrData}, 16'h005A);
        xf({8'h03, 16'hFFFF, 16'h0}, 40);
        chk("read wrap data", rx[15:0], 16'hFF5A);
        chk("read drives output", {15'h0, en}, 16'h0001);
        $display("test opcodes done");
        xf(48'h06, 8);
        supplyLow <= 1'b1;
        repeat (8) @(posedge core_clk);
        supplyLow <= 1'b0;
        repeat (4) @(posedge core_clk);
        chkSt("supply drop", 8'h00);
        $display("test supply done");
        end_sim;
    end
endmodule
